/* File: rtl/temperature_result_defs.vh */
// constants for the temperature result readout block
`ifndef TEMPERATURE_RESULT_DEFS_VH
`define TEMPERATURE_RESULT_DEFS_VH

`define CLOCK_MHZ             100
`define BUS_ADDR_FIXED        4'h9
`define PTR_RESULT            8'h00
`define PTR_CONFIG            8'h01
`define PTR_LIMIT_LOW         8'h02
`define PTR_LIMIT_HIGH        8'h03
`define PTR_NV_CONFIG         8'h11
`define PTR_NV_LIMIT_LOW      8'h12
`define PTR_NV_LIMIT_HIGH     8'h13
`define RESULT_RESET          16'h0000
`define RES_9BIT              2'h0
`define RES_10BIT             2'h1
`define RES_11BIT             2'h2
`define RES_12BIT             2'h3
`define MASK_9BIT             16'hFF80
`define MASK_10BIT            16'hFFC0
`define MASK_11BIT            16'hFFE0
`define MASK_12BIT            16'hFFF0
`define SIGN_BIT              15
`define IDLE_BYTE             8'hFF
// longest conversion time per resolution, microseconds
`define MAX_CONV_TIME_9_US    25
`define MAX_CONV_TIME_10_US   50
`define MAX_CONV_TIME_11_US   100
`define MAX_CONV_TIME_12_US   200
`define CONV_CYC_9   (`MAX_CONV_TIME_9_US * `CLOCK_MHZ)
`define CONV_CYC_10  (`MAX_CONV_TIME_10_US * `CLOCK_MHZ)
`define CONV_CYC_11  (`MAX_CONV_TIME_11_US * `CLOCK_MHZ)
`define CONV_CYC_12  (`MAX_CONV_TIME_12_US * `CLOCK_MHZ)

`endif

/* File: rtl/temp_conversion_timer.v */
// background conversion timebase producing masked two's-complement results
`timescale 1ns/100ps
`include "temperature_result_defs.vh"
module temp_conversion_timer #(
  parameter CONV_CYC_9  = `CONV_CYC_9,
  parameter CONV_CYC_10 = `CONV_CYC_10,
  parameter CONV_CYC_11 = `CONV_CYC_11,
  parameter CONV_CYC_12 = `CONV_CYC_12
) (
  input  wire        i_clock,         // system clock
  input  wire        i_rst_n,         // synchronous reset, active low
  input  wire        i_shutdown,      // stop continuous conversions
  input  wire [1:0]  i_resolution,    // selected resolution code
  input  wire [11:0] i_sensor_sample, // raw sample, 1/16 degree units
  output reg         o_done,          // one-cycle result strobe
  output reg  [15:0] o_data           // masked result
);
  reg [15:0] count_q;
  reg [1:0]  res_q;
  reg        running_q;
  reg        first_q;
  reg [15:0] reload;
  reg [15:0] mask;

  always @* begin
    case (i_resolution)
      `RES_9BIT:  reload = CONV_CYC_9[15:0] - 16'h0001;
      `RES_10BIT: reload = CONV_CYC_10[15:0] - 16'h0001;
      `RES_11BIT: reload = CONV_CYC_11[15:0] - 16'h0001;
      default:    reload = CONV_CYC_12[15:0] - 16'h0001;
    endcase
    case (res_q)
      `RES_9BIT:  mask = `MASK_9BIT;
      `RES_10BIT: mask = `MASK_10BIT;
      `RES_11BIT: mask = `MASK_11BIT;
      default:    mask = `MASK_12BIT;
    endcase
  end

  // resolution is latched at the start so a change mid-run cannot cut it short
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      count_q   <= 16'h0000;
      res_q     <= `RES_9BIT;
      running_q <= 1'b0;
      first_q   <= 1'b1;
      o_done    <= 1'b0;
      o_data    <= `RESULT_RESET;
    end else begin
      o_done <= 1'b0;
      if (running_q) begin
        if (count_q == 16'h0000) begin
          running_q <= 1'b0;
          o_done    <= 1'b1;
          // sample sits left-justified, sign lands in the top bit
          o_data    <= {i_sensor_sample, 4'h0} & mask;
        end else begin
          count_q <= count_q - 16'h0001;
        end
      end else if (!i_shutdown || first_q) begin
        first_q   <= 1'b0;
        running_q <= 1'b1;
        count_q   <= reload;
        res_q     <= i_resolution;
      end
    end
  end
endmodule

/* File: rtl/temperature_result_readout.v */
// two-wire target exposing the temperature result register
`timescale 1ns/100ps
`include "temperature_result_defs.vh"
module temperature_result_readout #(
  parameter CONV_CYC_9  = `CONV_CYC_9,
  parameter CONV_CYC_10 = `CONV_CYC_10,
  parameter CONV_CYC_11 = `CONV_CYC_11,
  parameter CONV_CYC_12 = `CONV_CYC_12
) (
  input  wire        i_clock,                  // system clock, 100 MHz
  input  wire        i_rst_n,                  // synchronous reset, low
  input  wire        i_scl,                    // bus clock level
  input  wire        i_sda,                    // bus data level
  output reg         o_sda_out,                // data drive value, always 0
  output reg         o_sda_oe,                 // high while pulling data low
  input  wire [2:0]  i_bus_address_select_pins, // address select straps
  input  wire [1:0]  i_resolution,             // resolution code
  input  wire        i_shutdown,               // shutdown mode
  input  wire [11:0] i_sensor_sample,          // raw sensor sample
  output reg  [15:0] o_temperature_result,     // result register copy
  output reg         o_read_active,            // result read under way
  output reg         o_update_pending          // result held back by read
);
  localparam ST_IDLE  = 8'h01;
  localparam ST_ADDR  = 8'h02;
  localparam ST_AACK  = 8'h04;
  localparam ST_WPTR  = 8'h08;
  localparam ST_PACK  = 8'h10;
  localparam ST_WDATA = 8'h20;
  localparam ST_TX    = 8'h40;
  localparam ST_TACK  = 8'h80;

  reg  [7:0]  state_q;
  reg  [3:0]  bit_cnt_q;
  reg  [7:0]  rx_q;
  reg  [7:0]  tx_q;
  reg  [7:0]  pointer_q;
  reg         upper_sent_q;
  reg         master_ack_q;
  reg         scl_q;
  reg         sda_q;
  reg  [15:0] pending_q;
  wire        conv_done;
  wire [15:0] conv_data;
  wire        scl_rise;
  wire        scl_fall;
  wire        start_cond;
  wire        stop_cond;
  wire [7:0]  rx_byte;
  wire        read_start;
  reg         ptr_valid;
  reg         release_read;

  temp_conversion_timer #(
    .CONV_CYC_9  (CONV_CYC_9),
    .CONV_CYC_10 (CONV_CYC_10),
    .CONV_CYC_11 (CONV_CYC_11),
    .CONV_CYC_12 (CONV_CYC_12)
  ) u_conv (
    .i_clock         (i_clock),
    .i_rst_n         (i_rst_n),
    .i_shutdown      (i_shutdown),
    .i_resolution    (i_resolution),
    .i_sensor_sample (i_sensor_sample),
    .o_done          (conv_done),
    .o_data          (conv_data)
  );

  assign scl_rise   = i_scl & ~scl_q;
  assign scl_fall   = ~i_scl & scl_q;
  assign start_cond = i_scl & scl_q & sda_q & ~i_sda;
  assign stop_cond  = i_scl & scl_q & ~sda_q & i_sda;
  assign rx_byte    = rx_q;
  // the upper byte is latched here, so a result finishing now must wait
  assign read_start = (state_q == ST_AACK) && scl_fall && rx_q[1] &&
                      (pointer_q == `PTR_RESULT);

  always @* begin
    case (rx_byte)
      `PTR_RESULT, `PTR_CONFIG, `PTR_LIMIT_LOW, `PTR_LIMIT_HIGH,
      `PTR_NV_CONFIG, `PTR_NV_LIMIT_LOW, `PTR_NV_LIMIT_HIGH:
        ptr_valid = 1'b1;
      default:
        ptr_valid = 1'b0;
    endcase
  end

  // a read ends on nack, start, stop, or at the word boundary of a re-read
  always @* begin
    release_read = 1'b0;
    if (start_cond || stop_cond) begin
      release_read = 1'b1;
    end else if (state_q == ST_TACK && scl_fall && upper_sent_q == 1'b0) begin
      release_read = 1'b1;
    end else if (state_q == ST_TACK && scl_fall && !master_ack_q) begin
      release_read = 1'b1;
    end
  end

  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
    end else begin
      scl_q   <= i_scl;
      sda_q   <= i_sda;
    end
  end

  // result register: a held-back result lands once the read lets go
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_temperature_result <= `RESULT_RESET;
      pending_q            <= `RESULT_RESET;
      o_update_pending     <= 1'b0;
    end else if (conv_done && !release_read &&
                 (o_read_active || read_start)) begin
      pending_q        <= conv_data;
      o_update_pending <= 1'b1;
    end else if (conv_done) begin
      o_temperature_result <= conv_data;
      o_update_pending     <= 1'b0;
    end else if (o_update_pending && (!o_read_active || release_read)) begin
      o_temperature_result <= pending_q;
      o_update_pending     <= 1'b0;
    end
  end

  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_q       <= ST_IDLE;
      bit_cnt_q     <= 4'h0;
      rx_q          <= 8'h00;
      tx_q          <= `IDLE_BYTE;
      pointer_q     <= `PTR_RESULT;
      upper_sent_q  <= 1'b0;
      master_ack_q  <= 1'b0;
      o_sda_oe      <= 1'b0;
      o_sda_out     <= 1'b0;
      o_read_active <= 1'b0;
    end else if (start_cond) begin
      state_q       <= ST_ADDR;
      bit_cnt_q     <= 4'h0;
      o_sda_oe      <= 1'b0;
      o_read_active <= 1'b0;
    end else if (stop_cond) begin
      state_q       <= ST_IDLE;
      o_sda_oe      <= 1'b0;
      o_read_active <= 1'b0;
    end else begin
      if (scl_rise) begin
        rx_q      <= {rx_q[6:0], i_sda};
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
      case (state_q)
        ST_IDLE: begin
          o_sda_oe <= 1'b0;
        end
        ST_ADDR: begin
          if (scl_fall && bit_cnt_q == 4'h8) begin
            if (rx_q[7:1] == {`BUS_ADDR_FIXED, i_bus_address_select_pins})
            begin
              o_sda_oe <= 1'b1;
              state_q  <= ST_AACK;
            end else begin
              state_q  <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            // the ack rise shifted one more bit in: direction sits at bit 1
            if (rx_q[1]) begin
              state_q      <= ST_TX;
              upper_sent_q <= 1'b1;
              if (pointer_q == `PTR_RESULT) begin
                o_read_active <= 1'b1;
                tx_q     <= o_temperature_result[15:8];
                o_sda_oe <= ~o_temperature_result[15];
              end else begin
                tx_q     <= `IDLE_BYTE;
                o_sda_oe <= 1'b0;
              end
            end else begin
              state_q  <= ST_WPTR;
              o_sda_oe <= 1'b0;
            end
          end
        end
        ST_WPTR: begin
          if (scl_fall && bit_cnt_q == 4'h8) begin
            if (ptr_valid) begin
              pointer_q <= rx_q;
              o_sda_oe  <= 1'b1;
              state_q   <= ST_PACK;
            end else begin
              state_q   <= ST_IDLE;
            end
          end
        end
        ST_PACK: begin
          if (scl_fall) begin
            o_sda_oe  <= 1'b0;
            bit_cnt_q <= 4'h0;
            state_q   <= ST_WDATA;
          end
        end
        ST_WDATA: begin
          // data bytes are counted but never stored or acknowledged
          o_sda_oe <= 1'b0;
          if (scl_fall && bit_cnt_q == 4'h8) begin
            bit_cnt_q <= 4'h0;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_q == 4'h8) begin
              o_sda_oe  <= 1'b0;
              bit_cnt_q <= 4'h0;
              state_q   <= ST_TACK;
            end else begin
              tx_q     <= {tx_q[6:0], 1'b1};
              o_sda_oe <= ~tx_q[6];
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            master_ack_q <= ~i_sda;
          end
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (!master_ack_q) begin
              o_sda_oe      <= 1'b0;
              o_read_active <= 1'b0;
              state_q       <= ST_IDLE;
            end else if (pointer_q != `PTR_RESULT) begin
              tx_q     <= `IDLE_BYTE;
              o_sda_oe <= 1'b0;
              state_q  <= ST_TX;
            end else if (upper_sent_q) begin
              upper_sent_q <= 1'b0;
              tx_q         <= o_temperature_result[7:0];
              o_sda_oe     <= ~o_temperature_result[7];
              state_q      <= ST_TX;
            end else begin
              // fresh word: take a result finishing now, else a held-back one, before the register
              upper_sent_q <= 1'b1;
              state_q      <= ST_TX;
              // a result finishing on this edge lands in the register itself
              if (conv_done) begin
                tx_q     <= conv_data[15:8];
                o_sda_oe <= ~conv_data[15];
              end else if (o_update_pending) begin
                tx_q     <= pending_q[15:8];
                o_sda_oe <= ~pending_q[15];
              end else begin
                tx_q     <= o_temperature_result[15:8];
                o_sda_oe <= ~o_temperature_result[15];
              end
            end
          end
        end
        default: begin
          state_q  <= ST_IDLE;
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end
endmodule

/* File: tb/result_readout_props.sv */
// concurrent checks on the result readout ports
`timescale 1ns/100ps
module result_readout_props (
  input wire        i_clock,              // clock
  input wire        i_rst_n,              // reset
  input wire        i_scl,                // bus clock
  input wire        o_sda_out,            // drive value
  input wire        o_sda_oe,             // drive enable
  input wire [15:0] o_temperature_result, // result
  input wire        o_read_active,        // read busy
  input wire        o_update_pending      // held result
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  reset_clear_a: assert property (disable iff (1'h0)
    !i_rst_n |=> !o_sda_oe && !o_read_active && !o_update_pending
      && o_temperature_result == 16'h0000) else $error("reset state wrong");
  open_drain_a: assert property (o_sda_out == 1'h0)
    else $error("data driven high");
  data_edge_a: assert property ($changed(o_sda_oe) |->
    !i_scl && !$past(i_scl)) else $error("data moved with clock high");
  held_stable_a: assert property (o_update_pending &&
    $past(o_update_pending) |-> $stable(o_temperature_result))
    else $error("held result moved");
  held_cause_a: assert property ($rose(o_update_pending) |->
    o_read_active) else $error("held without read");
  held_in_read_a: assert property (o_update_pending |->
    o_read_active || $past(o_read_active)) else $error("held after read");
  held_drain_a: assert property ($fell(o_read_active) |->
    ##[0:2] !o_update_pending) else $error("held result not loaded");
  low_zero_a: assert property (
    o_temperature_result[3:0] == 4'h0) else $error("low bits set");
  cover property ($rose(o_update_pending));
  cover property ($fell(o_read_active));
  cover property ($rose(o_sda_oe));
endmodule
bind temperature_result_readout result_readout_props chk_u (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_scl(i_scl),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_temperature_result(o_temperature_result),
  .o_read_active(o_read_active), .o_update_pending(o_update_pending));

/* File: tb/bus_master_model.sv */
// two-wire bus master model with open-drain data drive
`timescale 1ns/100ps
module bus_master_model (
  input  wire i_clock,          // clock
  input  wire i_sda,            // wire level
  output reg  o_scl = 1'h1,     // bus clock
  output reg  o_sda_low = 1'h0  // pulls data low
);
  task tick(input integer n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // each level is held two or four clocks so data never moves near a clock edge
  task ph(input s, input l, input integer n);
    o_scl = s;
    o_sda_low = l;
    tick(n);
  endtask
  task start;
    ph(o_scl, 1'h0, 2);
    ph(1'h1, 1'h0, 4);
    ph(1'h1, 1'h1, 4);
    ph(1'h0, 1'h1, 2);
  endtask
  task stop;
    ph(1'h0, 1'h1, 2);
    ph(1'h1, 1'h1, 4);
    ph(1'h1, 1'h0, 4);
  endtask
  task put(input b);
    ph(1'h0, !b, 2);
    ph(1'h1, !b, 4);
    ph(1'h0, !b, 2);
  endtask
  task get(output b);
    ph(1'h0, 1'h0, 2);
    ph(1'h1, 1'h0, 2);
    b = i_sda;
    ph(1'h1, 1'h0, 2);
    ph(1'h0, 1'h0, 2);
  endtask
  task wr(input [7:0] v, output ack);
    reg b;
    for (int k = 7; k >= 0; k--)
      put(v[k]);
    get(b);
    ack = !b;
  endtask
  task rd(output [7:0] v, input ack);
    for (int k = 7; k >= 0; k--)
      get(v[k]);
    put(!ack);
  endtask
endmodule

/* File: tb/temperature_result_readout_test.sv */
// self-checking bench for the temperature result readout
`timescale 1ns/100ps
module temperature_result_readout_test;
  localparam CONV = 20;
  reg         i_clock, i_rst_n, sd, ack;
  reg  [2:0]  pins;
  reg  [1:0]  res;
  reg  [11:0] smp;
  reg  [31:0] rnd;
  reg  [7:0]  hi, lo;
  reg  [15:0] model_q[$];
  wire        scl, sda_low, sda_oe;
  wire [15:0] result;
  wire        sda = !sda_oe && !sda_low;
  integer     mismatches = 0, total_checks = 0, cycles = 0, i;
  temperature_result_readout #(.CONV_CYC_9(CONV), .CONV_CYC_10(CONV),
    .CONV_CYC_11(CONV), .CONV_CYC_12(CONV)) dut_u (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda),
    .o_sda_out(), .o_sda_oe(sda_oe), .i_bus_address_select_pins(pins),
    .i_resolution(res), .i_shutdown(sd), .i_sensor_sample(smp),
    .o_temperature_result(result), .o_read_active(), .o_update_pending());
  bus_master_model m_u (.i_clock(i_clock), .i_sda(sda), .o_scl(scl),
    .o_sda_low(sda_low));
  function [15:0] want(input [11:0] s, input [1:0] r);
    want = {s, 4'h0} & ~(16'h007F >> r);
  endfunction
  task check(input [15:0] got, input [15:0] exp_v);
    total_checks = total_checks + 1;
    if (got !== exp_v) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp_v);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task addr(input rw, input [2:0] a);
    m_u.start;
    m_u.wr({4'h9, a, rw}, ack);
  endtask
  task read16(input [15:0] w);
    model_q.push_back(w);
    addr(1'h1, pins);
    check({15'h0000, ack}, 16'h0001);
    m_u.rd(hi, 1'h1);
    m_u.rd(lo, 1'h0);
    m_u.stop;
    check({hi, lo}, model_q.pop_front());
  endtask
  initial begin
    i_clock = 1'h0;
    forever #5 i_clock = ~i_clock;
  end
  // a hang in the bus handshake ends here instead of running forever
  always @(posedge i_clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      conclude;
    end
  end
  initial begin
    i_rst_n = 1'h0;
    sd = 1'h1;
    res = 2'h3;
    smp = 12'h7D0;
    rnd = $urandom(79332);
    pins = rnd[2:0];
    repeat (20) @(posedge i_clock);
    #1;
    i_rst_n = 1'h1;
    check(result, 16'h0000);
    m_u.tick(CONV + 6);
    check(result, 16'h7D00);
    smp = 12'hC90;
    m_u.tick(3 * CONV);
    check(result, 16'h7D00);
    sd = 1'h0;
    m_u.tick(3 * CONV);
    check(result, 16'hC900);
    for (i = 0; i < 4; i = i + 1) begin
      res = i[1:0];
      rnd = $urandom;
      smp = rnd[11:0];
      m_u.tick(3 * CONV);
      check(result, want(smp, res));
      read16(want(smp, res));
    end
    smp = 12'h194;
    m_u.tick(3 * CONV);
    addr(1'h1, pins);
    m_u.rd(hi, 1'h1);
    smp = 12'hE6C;
    m_u.rd(lo, 1'h1);
    check({hi, lo}, 16'h1940);
    m_u.rd(hi, 1'h1);
    m_u.rd(lo, 1'h0);
    m_u.stop;
    check({hi, lo}, 16'hE6C0);
    addr(1'h1, pins);
    m_u.rd(hi, 1'h0);
    m_u.rd(lo, 1'h0);
    m_u.stop;
    check({hi, lo}, 16'hE6FF);
    sd = 1'h1;
    m_u.tick(3 * CONV);
    addr(1'h0, pins);
    check({15'h0000, ack}, 16'h0001);
    m_u.wr(8'h00, ack);
    check({15'h0000, ack}, 16'h0001);
    m_u.wr(8'h5A, ack);
    m_u.stop;
    check({15'h0000, ack}, 16'h0000);
    check(result, 16'hE6C0);
    addr(1'h1, ~pins);
    m_u.stop;
    check({15'h0000, ack}, 16'h0000);
    conclude;
  end
endmodule
